// ---- link_adapt_asserts.sv ----
// assertions on the token link between the device and converter ends
`timescale 1ns/1ps
module link_adapt_asserts (
  input logic core_clk_i,
  input logic rst_i,
  input logic d2c_valid,
  input logic d2c_ready,
  input link_adapt_pkg::tok_t d2c_tok,
  input logic c2d_valid,
  input logic c2d_ready,
  input link_adapt_pkg::tok_t c2d_tok,
  input logic conv_ack,
  input logic dev_ack,
  input logic peer_is_converter
);
  logic d_acc;
  logic d_end;
  logic c_acc;
  logic c_end;
  assign d_acc = d2c_valid && d2c_ready && d2c_tok.kind == link_adapt_pkg::TK_DATA;
  assign d_end = d2c_tok.eop || d2c_tok.end_of_message_marker;
  assign c_acc = c2d_valid && c2d_ready;
  assign c_end = c2d_tok.eop || c2d_tok.end_of_message_marker || c2d_tok.kind == link_adapt_pkg::TK_NULL;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_D2C_HOLD: assert property (d2c_valid && !d2c_ready |=> d2c_valid && $stable(d2c_tok))
    else $error("device token changed before accept");
  AST_C2D_HOLD: assert property (c2d_valid && !c2d_ready |=> c2d_valid && $stable(c2d_tok))
    else $error("converter token changed before accept");
  AST_PEER_CONV: assert property (peer_is_converter)
    else $error("converter end not announced");
  AST_REQ_CHAN: assert property (d2c_valid && d2c_tok.kind == link_adapt_pkg::TK_REQ |-> d2c_tok.vc == 2'h1)
    else $error("length request on wrong channel");
  AST_NULL_EOM: assert property (c2d_valid && c2d_tok.kind == link_adapt_pkg::TK_NULL |-> c2d_tok.end_of_message_marker)
    else $error("empty message without end marker");
  AST_DEV_ACK: assert property (c_acc && c_end |=> dev_ack ##1 !dev_ack)
    else $error("device ack missing after packet end");
  AST_C2D_GAP: assert property (c_acc && c_end |=> !c2d_valid)
    else $error("converter token before device ack");
  AST_ACK_LATE: assert property (d_acc && d2c_tok.eop |=> !conv_ack)
    else $error("packet acked before buffering");
  AST_WAIT_ACK: assert property (d_acc && d_end |=> !(d2c_valid && d2c_tok.kind == link_adapt_pkg::TK_DATA))
    else $error("data sent before packet ack");
  AST_FLAGS: assert property (d2c_valid && d2c_tok.end_of_message_marker |-> !d2c_tok.eop)
    else $error("both packet end flags set");
  cover property (conv_ack);
  cover property (d2c_valid && !d2c_ready);
  cover property (c_acc && c2d_tok.kind == link_adapt_pkg::TK_NULL);
endmodule : link_adapt_asserts

// ---- link_adapt_pkg.sv ----
// shared constants and types for the byte-mode link adaptation
package link_adapt_pkg;

  localparam int unsigned NUM_LINKS = 4;
  localparam int unsigned BYTE_W = 8;
  // fifo entry: {eop, eom, data}
  localparam int unsigned FIFO_W = 10;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_EOP_BIT = 9;
  localparam int unsigned FIFO_EOM_BIT = 8;
  // bytes per packet before a packet terminator is forced
  localparam logic [5:0] PKT_BYTES = 6'h20;
  localparam logic [5:0] PKT_LAST = 6'h1f;
  localparam logic [5:0] PKT_CNT_RST = 6'h00;
  localparam logic [5:0] PKT_CNT_ONE = 6'h01;
  localparam logic [7:0] REQ_CNT_RST = 8'h00;
  localparam logic [7:0] REQ_CNT_ONE = 8'h01;
  // channel numbers carried in the token
  localparam logic [1:0] DATA_VC = 2'h0;
  localparam logic [1:0] REQ_VC = 2'h1;

  typedef enum logic [1:0] {
    TK_DATA,
    TK_HDR,
    TK_REQ,
    TK_NULL
  } tok_kind_t;

  typedef struct packed {
    tok_kind_t kind;
    logic [1:0] vc;
    logic [7:0] data;
    logic eop;
    logic end_of_message_marker;
  } tok_t;

  typedef enum logic [1:0] {
    DV_IDLE,
    DV_HDR,
    DV_DATA,
    DV_WAIT_ACK
  } dev_state_t;

endpackage : link_adapt_pkg

// ---- link_converter_end.sv ----
// protocol converter end: outgoing byte fifo, legacy byte stream and input packetizer
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input logic core_clk_i,
  input logic rst_i,
  input logic in_valid_i,
  output logic in_ready_o,
  input logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] cnt;
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic push;
  logic pop;

  assign in_ready_o = (q.cnt != CNT_FULL);
  assign out_valid_o = (q.cnt != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = q.mem[q.rd];

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr = (q.wr == PTR_LAST) ? '0 : q.wr + PTR_ONE;
    end
    if (pop) begin
      d.rd = (q.rd == PTR_LAST) ? '0 : q.rd + PTR_ONE;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + CNT_ONE;
    end else if (pop && !push) begin
      d.cnt = q.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : byte_fifo

module link_converter_end (
  input logic core_clk_i,
  input logic rst_i,
  link_if.conv lnk,
  output logic os_tx_valid_o,
  output logic [7:0] os_tx_data_o,
  input logic os_tx_ack_i,
  input logic os_rx_valid_i,
  input logic [7:0] os_rx_data_i,
  output logic os_rx_ready_o,
  output logic [7:0] req_count_o
);

  typedef struct packed {
    logic ack_pend;
    logic conv_ack;
    logic os_valid;
    logic [7:0] os_data;
    logic os_eom;
    logic byte_valid;
    logic [7:0] byte_data;
    logic null_sent;
    logic [7:0] req_count;
    logic [5:0] pkt_cnt;
    logic c2d_wait;
    logic c2d_valid;
    link_adapt_pkg::tok_t c2d_tok;
  } conv_st_t;

  conv_st_t q;
  conv_st_t d;
  logic is_data;
  logic is_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [link_adapt_pkg::FIFO_W-1:0] fifo_out_data;
  logic wr;
  logic os_free;
  logic c2d_free;
  logic [7:0] req_add;
  logic [7:0] req_dec;

  assign is_data = lnk.d2c_valid && (lnk.d2c_tok.kind == link_adapt_pkg::TK_DATA);
  assign is_req = lnk.d2c_valid && (lnk.d2c_tok.kind == link_adapt_pkg::TK_REQ);
  // only data waits on the fifo; requests and headers are always taken
  assign lnk.d2c_ready = is_data ? fifo_in_ready : 1'b1;
  assign wr = is_data && fifo_in_ready;
  // a byte in flight frees its slot on the same edge as its ack
  assign os_free = !q.os_valid || os_tx_ack_i;
  assign fifo_out_ready = os_free;
  assign c2d_free = !q.c2d_valid || lnk.c2d_ready;
  assign req_add = is_req ? lnk.d2c_tok.data : link_adapt_pkg::REQ_CNT_RST;

  byte_fifo #(
    .WIDTH(link_adapt_pkg::FIFO_W),
    .DEPTH(link_adapt_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(is_data),
    .in_ready_o(fifo_in_ready),
    .in_data_i({lnk.d2c_tok.eop, lnk.d2c_tok.end_of_message_marker, lnk.d2c_tok.data}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    d = q;
    d.conv_ack = 1'b0;
    req_dec = link_adapt_pkg::REQ_CNT_RST;
    // intermediate packet: ack once a further slot is free
    if (q.ack_pend && fifo_in_ready) begin
      d.ack_pend = 1'b0;
      d.conv_ack = 1'b1;
    end
    if (wr && lnk.d2c_tok.eop && !lnk.d2c_tok.end_of_message_marker) begin
      d.ack_pend = 1'b1;
    end
    if (q.os_valid && os_tx_ack_i) begin
      d.os_valid = 1'b0;
      if (q.os_eom) begin
        // final packet of a message waits for the legacy ack of its last byte
        d.conv_ack = 1'b1;
      end
    end
    if (fifo_out_valid && os_free) begin
      d.os_valid = 1'b1;
      d.os_data = fifo_out_data[7:0];
      d.os_eom = fifo_out_data[link_adapt_pkg::FIFO_EOM_BIT];
    end
    if (lnk.c2d_ready) begin
      d.c2d_valid = 1'b0;
    end
    if (lnk.dev_ack) begin
      d.c2d_wait = 1'b0;
    end
    if (q.byte_valid && c2d_free && !q.c2d_wait) begin
      if (q.req_count != link_adapt_pkg::REQ_CNT_RST) begin
        d.c2d_valid = 1'b1;
        d.c2d_tok = '{kind: link_adapt_pkg::TK_DATA, vc: link_adapt_pkg::DATA_VC,
                      data: q.byte_data,
                      eop: (q.pkt_cnt == link_adapt_pkg::PKT_LAST),
                      end_of_message_marker: (q.req_count == link_adapt_pkg::REQ_CNT_ONE)};
        req_dec = link_adapt_pkg::REQ_CNT_ONE;
        d.byte_valid = 1'b0;
        d.null_sent = 1'b0;
        if ((q.pkt_cnt == link_adapt_pkg::PKT_LAST) || (q.req_count == link_adapt_pkg::REQ_CNT_ONE)) begin
          d.pkt_cnt = link_adapt_pkg::PKT_CNT_RST;
          d.c2d_wait = 1'b1;
        end else begin
          d.pkt_cnt = q.pkt_cnt + link_adapt_pkg::PKT_CNT_ONE;
        end
      end else if (!q.null_sent) begin
        // byte stays held until a request claims it; notify only once
        d.c2d_valid = 1'b1;
        d.c2d_tok = '{kind: link_adapt_pkg::TK_NULL, vc: link_adapt_pkg::DATA_VC,
                      data: 8'h00, eop: 1'b0, end_of_message_marker: 1'b1};
        d.null_sent = 1'b1;
        d.c2d_wait = 1'b1;
      end
    end
    // count wraps at the byte width; outstanding requests must stay below it
    d.req_count = 8'(q.req_count + req_add - req_dec);
    if (os_rx_valid_i && !q.byte_valid) begin
      d.byte_valid = 1'b1;
      d.byte_data = os_rx_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // marks this end as a converter so a byte-mode device will talk to it
  assign lnk.peer_is_converter = 1'b1;
  assign lnk.conv_ack = q.conv_ack;
  assign lnk.c2d_valid = q.c2d_valid;
  assign lnk.c2d_tok = q.c2d_tok;
  assign os_tx_valid_o = q.os_valid;
  assign os_tx_data_o = q.os_data;
  assign os_rx_ready_o = !q.byte_valid;
  assign req_count_o = q.req_count;

endmodule : link_converter_end

// ---- link_device_end.sv ----
// device end of one data link: packetizer, input requests and receive path
`timescale 1ns/1ps
module link_device_end #(
  parameter int unsigned LINK_ID = 0
) (
  input logic core_clk_i,
  input logic rst_i,
  link_if.dev lnk,
  input logic [3:0] link_mode_select_regs_i,
  input logic tx_valid_i,
  input logic [7:0] tx_data_i,
  input logic tx_last_i,
  input logic [1:0] tx_vc_i,
  output logic tx_ready_o,
  output logic tx_done_o,
  input logic rx_req_valid_i,
  input logic [7:0] rx_req_len_i,
  output logic rx_req_ready_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  input logic rx_ready_i,
  output logic rx_unsol_o,
  output logic mode_fault_o
);

  typedef struct packed {
    link_adapt_pkg::dev_state_t st;
    logic msg_byte;
    logic last_pkt;
    logic [1:0] cur_vc;
    logic [5:0] pkt_cnt;
    logic out_valid;
    link_adapt_pkg::tok_t out_tok;
    logic tx_done;
    logic dev_ack;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_last;
    logic rx_unsol;
    logic fault;
  } dev_st_t;

  dev_st_t q;
  dev_st_t d;
  logic byte_mode;
  logic link_ok;
  logic out_free;
  logic req_take;
  logic tx_take;
  logic c2d_take;
  logic pkt_end;

  assign byte_mode = link_mode_select_regs_i[LINK_ID];
  // byte mode only talks to a converter; a bare device peer is refused
  assign link_ok = !byte_mode || lnk.peer_is_converter;
  assign out_free = !q.out_valid || lnk.d2c_ready;
  assign req_take = rx_req_valid_i && out_free && link_ok &&
                    ((q.st == link_adapt_pkg::DV_IDLE) || (q.st == link_adapt_pkg::DV_WAIT_ACK));
  assign tx_take = tx_valid_i && out_free && (q.st == link_adapt_pkg::DV_DATA);
  assign c2d_take = lnk.c2d_valid && lnk.c2d_ready;
  assign pkt_end = (q.pkt_cnt == link_adapt_pkg::PKT_LAST) || tx_last_i;

  always_comb begin
    d = q;
    d.tx_done = 1'b0;
    d.dev_ack = 1'b0;
    d.rx_unsol = 1'b0;
    d.fault = byte_mode && !lnk.peer_is_converter;
    if (lnk.d2c_ready) begin
      d.out_valid = 1'b0;
    end
    if (req_take) begin
      // length request rides its own channel, never the data channel
      d.out_valid = 1'b1;
      d.out_tok = '{kind: link_adapt_pkg::TK_REQ, vc: link_adapt_pkg::REQ_VC,
                    data: rx_req_len_i, eop: 1'b0, end_of_message_marker: 1'b1};
    end
    case (q.st)
      link_adapt_pkg::DV_IDLE: begin
        if (!req_take && tx_valid_i && link_ok) begin
          // mode is latched per message so a mid-message change cannot split it
          d.msg_byte = byte_mode;
          d.pkt_cnt = link_adapt_pkg::PKT_CNT_RST;
          d.cur_vc = byte_mode ? link_adapt_pkg::DATA_VC : tx_vc_i;
          d.st = byte_mode ? link_adapt_pkg::DV_DATA : link_adapt_pkg::DV_HDR;
        end
      end
      link_adapt_pkg::DV_HDR: begin
        if (out_free) begin
          d.out_valid = 1'b1;
          d.out_tok = '{kind: link_adapt_pkg::TK_HDR, vc: q.cur_vc,
                        data: {6'h00, q.cur_vc}, eop: 1'b0, end_of_message_marker: 1'b0};
          d.st = link_adapt_pkg::DV_DATA;
        end
      end
      link_adapt_pkg::DV_DATA: begin
        if (tx_take) begin
          d.out_valid = 1'b1;
          d.out_tok = '{kind: link_adapt_pkg::TK_DATA, vc: q.cur_vc, data: tx_data_i,
                        eop: pkt_end && !tx_last_i, end_of_message_marker: tx_last_i};
          d.pkt_cnt = q.pkt_cnt + link_adapt_pkg::PKT_CNT_ONE;
          if (pkt_end) begin
            d.last_pkt = tx_last_i;
            d.st = link_adapt_pkg::DV_WAIT_ACK;
          end
        end
      end
      link_adapt_pkg::DV_WAIT_ACK: begin
        if (lnk.conv_ack) begin
          d.pkt_cnt = link_adapt_pkg::PKT_CNT_RST;
          if (q.last_pkt) begin
            // next message only once this one is fully acknowledged
            d.tx_done = 1'b1;
            d.st = link_adapt_pkg::DV_IDLE;
          end else begin
            d.st = q.msg_byte ? link_adapt_pkg::DV_DATA : link_adapt_pkg::DV_HDR;
          end
        end
      end
      default: begin
        d.st = link_adapt_pkg::DV_IDLE;
      end
    endcase
    if (rx_ready_i) begin
      d.rx_valid = 1'b0;
    end
    if (c2d_take) begin
      case (lnk.c2d_tok.kind)
        link_adapt_pkg::TK_NULL: begin
          d.rx_unsol = 1'b1;
          d.dev_ack = 1'b1;
        end
        link_adapt_pkg::TK_DATA: begin
          // message end is delivered with its last byte, never merged onward
          d.rx_valid = 1'b1;
          d.rx_data = lnk.c2d_tok.data;
          d.rx_last = lnk.c2d_tok.end_of_message_marker;
          d.dev_ack = lnk.c2d_tok.eop || lnk.c2d_tok.end_of_message_marker;
        end
        default: begin
          d.dev_ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.d2c_valid = q.out_valid;
  assign lnk.d2c_tok = q.out_tok;
  assign lnk.c2d_ready = !q.rx_valid || rx_ready_i;
  assign lnk.dev_ack = q.dev_ack;
  assign tx_ready_o = out_free && (q.st == link_adapt_pkg::DV_DATA);
  assign tx_done_o = q.tx_done;
  assign rx_req_ready_o = req_take;
  assign rx_valid_o = q.rx_valid;
  assign rx_data_o = q.rx_data;
  assign rx_last_o = q.rx_last;
  assign rx_unsol_o = q.rx_unsol;
  assign mode_fault_o = q.fault;

endmodule : link_device_end

// ---- link_if.sv ----
// token link between the device end and the protocol converter end
`timescale 1ns/1ps
interface link_if (
  input logic core_clk_i,
  input logic rst_i
);
  logic d2c_valid;
  logic d2c_ready;
  link_adapt_pkg::tok_t d2c_tok;
  logic c2d_valid;
  logic c2d_ready;
  link_adapt_pkg::tok_t c2d_tok;
  logic conv_ack;
  logic dev_ack;
  logic peer_is_converter;

  modport dev (
    output d2c_valid,
    output d2c_tok,
    output c2d_ready,
    output dev_ack,
    input d2c_ready,
    input c2d_valid,
    input c2d_tok,
    input conv_ack,
    input peer_is_converter
  );

  modport conv (
    input d2c_valid,
    input d2c_tok,
    input c2d_ready,
    input dev_ack,
    output d2c_ready,
    output c2d_valid,
    output c2d_tok,
    output conv_ack,
    output peer_is_converter
  );
endinterface : link_if

// ---- test_byte_mode_link_adaptation.sv ----
// self-checking bench for the device end and converter end joined back to back
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin logic [31:0] chk_e; logic [31:0] chk_g; chk_e = 32'(ex); chk_g = 32'(got); \
  samples_checked++; if (chk_g !== chk_e) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, chk_e, chk_g); end end
module test_byte_mode_link_adaptation;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] mode = 4'h1;
  logic tx_valid_i = 1'b0, tx_last_i = 1'b0, rx_req_valid_i = 1'b0, rx_ready_i = 1'b0;
  logic os_tx_ack_i = 1'b0, os_rx_valid_i = 1'b0, stall = 1'b1, full_seen = 1'b0;
  logic [7:0] tx_data_i = 8'h00, rx_req_len_i = 8'h00, os_rx_data_i = 8'h00;
  logic [1:0] tx_vc_i = 2'h2;
  logic [31:0] rnd = 32'h0572_0d22;
  logic tx_ready_o, tx_done_o, rx_req_ready_o, rx_valid_o, rx_last_o, rx_unsol_o, b_ready, b_fault, a_fault;
  logic os_tx_valid_o, os_rx_ready_o;
  logic [7:0] rx_data_o, os_tx_data_o, req_count_o;
  logic [7:0] exp_os[$];
  logic [8:0] exp_rx[$];
  int bad_count = 0, samples_checked = 0, cyc = 0, done_cnt = 0, unsol_cnt = 0, hdr_cnt = 0;

  link_if lnk (.core_clk_i, .rst_i);
  link_if lnk_b (.core_clk_i, .rst_i);
  // second link: a byte-mode end wired to something that is not a converter
  assign lnk_b.d2c_ready = 1'b1;
  assign lnk_b.c2d_valid = 1'b0;
  assign lnk_b.c2d_tok = '0;
  assign lnk_b.conv_ack = 1'b0;
  assign lnk_b.peer_is_converter = 1'b0;

  link_device_end #(.LINK_ID(0)) u_link_device_end (.core_clk_i, .rst_i, .lnk(lnk), .link_mode_select_regs_i(mode),
    .tx_valid_i, .tx_data_i, .tx_last_i, .tx_vc_i, .tx_ready_o, .tx_done_o, .rx_req_valid_i, .rx_req_len_i,
    .rx_req_ready_o, .rx_valid_o, .rx_data_o, .rx_last_o, .rx_ready_i, .rx_unsol_o, .mode_fault_o(a_fault));
  link_device_end #(.LINK_ID(0)) u_link_device_end_b (.core_clk_i, .rst_i, .lnk(lnk_b), .link_mode_select_regs_i(mode),
    .tx_valid_i, .tx_data_i, .tx_last_i, .tx_vc_i, .tx_ready_o(b_ready), .tx_done_o(), .rx_req_valid_i, .rx_req_len_i,
    .rx_req_ready_o(), .rx_valid_o(), .rx_data_o(), .rx_last_o(), .rx_ready_i, .rx_unsol_o(), .mode_fault_o(b_fault));
  link_converter_end u_link_converter_end (.core_clk_i, .rst_i, .lnk(lnk), .os_tx_valid_o, .os_tx_data_o,
    .os_tx_ack_i, .os_rx_valid_i, .os_rx_data_i, .os_rx_ready_o, .req_count_o);
  link_adapt_asserts u_link_adapt_asserts (.core_clk_i, .rst_i, .d2c_valid(lnk.d2c_valid), .d2c_ready(lnk.d2c_ready),
    .d2c_tok(lnk.d2c_tok), .c2d_valid(lnk.c2d_valid), .c2d_ready(lnk.c2d_ready), .c2d_tok(lnk.c2d_tok),
    .conv_ack(lnk.conv_ack), .dev_ack(lnk.dev_ack), .peer_is_converter(lnk.peer_is_converter));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // random acceptance on both far sides keeps the stall paths busy
  always @(negedge core_clk_i) begin
    rnd <= lfsr(rnd);
    os_tx_ack_i <= !stall && rnd[0];
    rx_ready_i <= rnd[1] | rnd[2];
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
    if (!rst_i) begin
      if (os_tx_valid_o && os_tx_ack_i) begin
        `CHK("legacy note", 1'b1, exp_os.size() != 0)
        `CHK("legacy byte", exp_os.pop_front(), os_tx_data_o)
      end
      if (rx_valid_o && rx_ready_i) begin
        `CHK("received note", 1'b1, exp_rx.size() != 0)
        `CHK("received byte", exp_rx.pop_front(), {rx_last_o, rx_data_o})
      end
      if (tx_done_o) begin
        done_cnt++;
        `CHK("legacy drained at done", 0, exp_os.size())
      end
      if (rx_unsol_o) unsol_cnt++;
      if (lnk.d2c_valid && !lnk.d2c_ready) full_seen = 1'b1;
      if (lnk.d2c_valid && lnk.d2c_ready && lnk.d2c_tok.kind === link_adapt_pkg::TK_HDR) begin
        hdr_cnt++;
        `CHK("header channel", 8'h02, lnk.d2c_tok.data)
      end
      if (tx_valid_i && mode[0]) `CHK("refused start", 1'b0, b_ready)
    end
  end

  task automatic send_msg(input int n, input logic bm);
    int k;
    int d0;
    d0 = done_cnt;
    @(negedge core_clk_i);
    mode = {rnd[30:28], bm};
    for (k = 0; k < n; k++) begin
      tx_valid_i = 1'b1;
      tx_data_i = rnd[23:16];
      tx_last_i = k == n - 1;
      exp_os.push_back(rnd[23:16]);
      @(posedge core_clk_i iff tx_ready_o);
      @(negedge core_clk_i);
    end
    tx_valid_i = 1'b0;
    while (done_cnt == d0) @(posedge core_clk_i);
  endtask : send_msg

  task automatic req(input logic [7:0] len);
    @(negedge core_clk_i);
    rx_req_valid_i = 1'b1;
    rx_req_len_i = len;
    @(posedge core_clk_i iff rx_req_ready_o);
    @(negedge core_clk_i);
    rx_req_valid_i = 1'b0;
  endtask : req

  task automatic os_byte(input logic last);
    @(negedge core_clk_i);
    os_rx_valid_i = 1'b1;
    os_rx_data_i = rnd[15:8];
    exp_rx.push_back({last, rnd[15:8]});
    @(posedge core_clk_i iff os_rx_ready_o);
    @(negedge core_clk_i);
    os_rx_valid_i = 1'b0;
  endtask : os_byte

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    fork
      begin
        repeat (30) @(posedge core_clk_i);
        stall = 1'b0;
      end
    join_none
    // 40 bytes split into two packets while the legacy side stalls
    send_msg(40, 1'b1);
    `CHK("fifo refused", 1'b1, full_seen)
    `CHK("mode fault", 1'b1, b_fault)
    `CHK("converter peer fault", 1'b0, a_fault)
    send_msg(4, 1'b1);
    `CHK("byte mode headers", 0, hdr_cnt)
    send_msg(3, 1'b0);
    `CHK("channel mode headers", 1, hdr_cnt)
    `CHK("messages done", 3, done_cnt)
    req(8'h02);
    req(8'h01);
    repeat (2) @(posedge core_clk_i);
    `CHK("request count", 8'h03, req_count_o)
    os_byte(1'b0);
    os_byte(1'b0);
    os_byte(1'b1);
    while (exp_rx.size() != 0) @(posedge core_clk_i);
    `CHK("request drained", 8'h00, req_count_o)
    os_byte(1'b1);
    repeat (10) @(posedge core_clk_i);
    `CHK("unsolicited notice", 1, unsol_cnt)
    `CHK("byte held", 1, exp_rx.size())
    req(8'h01);
    while (exp_rx.size() != 0) @(posedge core_clk_i);
    `CHK("single notice", 1, unsol_cnt)
    conclude();
  end
endmodule : test_byte_mode_link_adaptation
